/* File: srcr_pkg.sv */
package srcr_pkg;

    localparam logic [3:0] SRCR_ADDR_SLEEP_DEPTH_BIT_MODE = 4'h0;
    localparam logic [3:0] SRCR_ADDR_RAM_CTRL = 4'h1;
    localparam logic [3:0] SRCR_ADDR_STATUS = 4'h2;

    localparam int SRCR_BIT_TRACE_RST = 7;
    localparam int SRCR_BIT_PIN_FLOAT = 6;
    localparam int SRCR_BIT_DEEP_SEL = 1;
    localparam int SRCR_BIT_RAM_EN = 4;

    localparam logic [7:0] SRCR_SLEEP_DEPTH_BIT_MODE_RST = 8'h00;
    localparam logic [7:0] SRCR_RAM_CTRL_RST = 8'h10;
    localparam logic [7:0] SRCR_SLEEP_DEPTH_BIT_MODE_MASK = 8'hC2;
    localparam logic [7:0] SRCR_RAM_CTRL_MASK = 8'h10;
    localparam logic [7:0] SRCR_UNDEF_DATA = 8'h00;

    localparam int SRCR_RAM_AW = 4;
    localparam int SRCR_PIN_W = 8;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } srcr_reg_req_t;

    typedef struct packed {
        logic [SRCR_RAM_AW-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } srcr_ram_req_t;

    typedef enum logic [1:0] {
        SRCR_RUN = 2'b01,
        SRCR_STANDBY = 2'b10
    } srcr_state_t;

endpackage : srcr_pkg

/* File: srcr_ram.sv */
`timescale 1ns/10ps
module srcr_ram
    import srcr_pkg::*;
#(
    parameter int AW = SRCR_RAM_AW
) (
    input wire logic clk_sys, // system clock
    input wire logic rstn, // async reset, low
    input wire logic en, // ram access enable
    input wire logic [AW-1:0] addr, // word index
    input wire logic [7:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read or fetch strobe
    output logic [7:0] rdata_q // read data, one cycle later
);

    logic [7:0] mem_q [2**AW];
    logic do_wr;
    logic [7:0] rdata_d;

    assign do_wr = wr & en;
    assign rdata_d = en ? mem_q[addr] : SRCR_UNDEF_DATA;

    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem_q[addr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            rdata_q <= rdata_d;
        end
    end

endmodule : srcr_ram

/* File: srcr_top.sv */
`timescale 1ns/10ps
module srcr_top
    import srcr_pkg::*;
#(
    parameter int PW = SRCR_PIN_W
) (
    input wire logic clk_sys, // system clock
    input wire logic rstn, // async reset, low
    input wire srcr_reg_req_t reg_req, // register request
    output logic [7:0] reg_rdata_q, // register read data
    input wire logic sleep_exec, // sleep instruction pulse
    input wire logic sleep_depth_bit, // depth bit of first control
    input wire logic standby_wake, // wake event pulse
    input wire srcr_ram_req_t ram_req, // cpu ram request
    output logic [7:0] ram_rdata_q, // cpu ram read data
    input wire logic [PW-1:0] pin_out, // port output values
    input wire logic [PW-1:0] pin_oe, // port output enables
    output logic [PW-1:0] pad_out_q, // pad output values
    output logic [PW-1:0] pad_oe_q, // pad output enables
    output logic trace_unit_rst_n_q, // trace unit reset, low
    output logic standby_q // software standby active
);

    logic [7:0] sleep_depth_bit_mode_q;
    logic [7:0] ram_ctrl_q;
    srcr_state_t state_q;
    srcr_state_t state_d;
    logic wr_sleep_depth_bit;
    logic wr_ram;
    logic [7:0] rd_mux;
    logic enter_standby;
    logic standby_pin_float;
    logic deep_standby_select;
    logic ram_access_enable;
    logic [PW-1:0] pad_out_d;
    logic [PW-1:0] pad_oe_d;

    function automatic logic hit(input srcr_reg_req_t r,
                                 input logic [3:0] a);
        hit = r.addr == a;
    endfunction : hit

    assign wr_sleep_depth_bit = reg_req.wr & hit(reg_req, SRCR_ADDR_SLEEP_DEPTH_BIT_MODE);
    assign wr_ram = reg_req.wr & hit(reg_req, SRCR_ADDR_RAM_CTRL);

    assign standby_pin_float = sleep_depth_bit_mode_q[SRCR_BIT_PIN_FLOAT];
    assign deep_standby_select = sleep_depth_bit_mode_q[SRCR_BIT_DEEP_SEL];
    assign ram_access_enable = ram_ctrl_q[SRCR_BIT_RAM_EN];

    assign rd_mux = hit(reg_req, SRCR_ADDR_SLEEP_DEPTH_BIT_MODE) ? sleep_depth_bit_mode_q :
                    hit(reg_req, SRCR_ADDR_RAM_CTRL) ? ram_ctrl_q :
                    hit(reg_req, SRCR_ADDR_STATUS) ?
                        {7'h00, state_q == SRCR_STANDBY} : 8'h00;

    assign enter_standby = sleep_exec & sleep_depth_bit
                           & deep_standby_select;

    always_comb begin
        state_d = state_q;
        case (state_q)
            SRCR_RUN: begin
                if (enter_standby) begin
                    state_d = SRCR_STANDBY;
                end
            end
            SRCR_STANDBY: begin
                if (standby_wake) begin
                    state_d = SRCR_RUN;
                end
            end
            default: begin
                state_d = SRCR_RUN;
            end
        endcase
    end

    // pads: live outside standby, frozen or floated inside it
    assign pad_out_d = (state_d == SRCR_STANDBY) ? pad_out_q : pin_out;
    assign pad_oe_d = (state_d != SRCR_STANDBY) ? pin_oe :
                      standby_pin_float ? '0 : pad_oe_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sleep_depth_bit_mode_q <= SRCR_SLEEP_DEPTH_BIT_MODE_RST;
        end else if (wr_sleep_depth_bit) begin
            sleep_depth_bit_mode_q <= reg_req.wdata & SRCR_SLEEP_DEPTH_BIT_MODE_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ram_ctrl_q <= SRCR_RAM_CTRL_RST;
        end else if (wr_ram) begin
            ram_ctrl_q <= reg_req.wdata & SRCR_RAM_CTRL_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= SRCR_RUN;
            standby_q <= 1'b0;
            reg_rdata_q <= 8'h00;
            trace_unit_rst_n_q <= 1'b0;
            pad_out_q <= '0;
            pad_oe_q <= '0;
        end else begin
            state_q <= state_d;
            standby_q <= state_d == SRCR_STANDBY;
            reg_rdata_q <= reg_req.rd ? rd_mux : 8'h00;
            trace_unit_rst_n_q <= wr_sleep_depth_bit ?
                reg_req.wdata[SRCR_BIT_TRACE_RST] :
                sleep_depth_bit_mode_q[SRCR_BIT_TRACE_RST];
            pad_out_q <= pad_out_d;
            pad_oe_q <= pad_oe_d;
        end
    end

    // no hazard here; ram enable takes effect the next cycle
    srcr_ram #(
        .AW(SRCR_RAM_AW)
    ) u_ram (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .en(ram_access_enable),
        .addr(ram_req.addr),
        .wdata(ram_req.wdata),
        .wr(ram_req.wr),
        .rd(ram_req.rd),
        .rdata_q(ram_rdata_q)
    );

endmodule : srcr_top

/* File: srcr_top_monitor.sv */
`timescale 1ns/10ps
module srcr_top_monitor
    import srcr_pkg::*;
#(parameter int PW = SRCR_PIN_W) (
    input wire logic clk_sys, // system clock
    input wire logic rstn, // async reset, low
    input wire srcr_reg_req_t reg_req, // register request
    input wire logic [7:0] reg_rdata_q, // register read data
    input wire logic sleep_exec, // sleep pulse
    input wire logic sleep_depth_bit, // depth bit
    input wire logic standby_wake, // wake pulse
    input wire srcr_ram_req_t ram_req, // ram request
    input wire logic [7:0] ram_rdata_q, // ram read data
    input wire logic [PW-1:0] pin_out, // port values
    input wire logic [PW-1:0] pin_oe, // port enables
    input wire logic [PW-1:0] pad_out_q, // pad values
    input wire logic [PW-1:0] pad_oe_q, // pad enables
    input wire logic trace_unit_rst_n_q, // trace reset, low
    input wire logic standby_q // standby active
);
    logic [7:0] mode_q;
    logic ram_en_q;
    wire rq0 = reg_req.addr == SRCR_ADDR_SLEEP_DEPTH_BIT_MODE;
    wire rq1 = reg_req.addr == SRCR_ADDR_RAM_CTRL;
    wire go = sleep_exec && sleep_depth_bit && mode_q[1];
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode_q <= 8'h00;
            ram_en_q <= 1'b1;
        end else if (reg_req.wr) begin
            if (rq0) mode_q <= reg_req.wdata & SRCR_SLEEP_DEPTH_BIT_MODE_MASK;
            if (rq1) ram_en_q <= reg_req.wdata[4];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_go;
        !standby_q && go;
    endsequence
    chk_trace_rel_follow:
        assert property (reg_req.wr && rq0 |=>
            trace_unit_rst_n_q == $past(reg_req.wdata[7])) else $error("trace");
    chk_mode_read_back:
        assert property (reg_req.rd && rq0 |=> reg_rdata_q == mode_q)
            else $error("mode read");
    chk_ramctl_read_back:
        assert property (reg_req.rd && rq1 |=>
            reg_rdata_q == {3'h0, ram_en_q, 4'h0}) else $error("ramctl read");
    chk_float_oe_zero:
        assert property (standby_q && mode_q[6] |-> pad_oe_q == '0)
            else $error("float");
    chk_hold_pads_still:
        assert property (standby_q && !mode_q[6] ##1 standby_q |->
            $stable(pad_out_q) && $stable(pad_oe_q)) else $error("hold");
    chk_sleep_enter_ok:
        assert property (s_go |=> standby_q) else $error("no entry");
    chk_sleep_no_enter:
        assert property (!standby_q && !go |=> !standby_q)
            else $error("bad entry");
    chk_ram_off_read:
        assert property (ram_req.rd && !ram_en_q |=>
            ram_rdata_q == SRCR_UNDEF_DATA) else $error("ram off");
endmodule : srcr_top_monitor
bind srcr_top srcr_top_monitor #(.PW(PW)) mon (.*);

/* File: srcr_top_test.sv */
`timescale 1ns/10ps
module srcr_top_test;
    import srcr_pkg::*;
    logic clk_sys = 0, rstn = 0, sleep_exec = 0;
    logic sleep_depth_bit = 0, standby_wake = 0;
    srcr_reg_req_t reg_req = '0;
    srcr_ram_req_t ram_req = '0;
    logic [7:0] pin_out = 0, pin_oe = 0, reg_rdata_q, ram_rdata_q;
    logic [7:0] pad_out_q, pad_oe_q, ho, he;
    logic trace_unit_rst_n_q, standby_q;
    int mismatches = 0, n_checks = 0, cycles = 0, mode = 0, ramen = 1;
    int seed = 32'hd27b64a5, r, mem[16], sby = 0;
    always #2 clk_sys = ~clk_sys;
    srcr_top dut (.*);
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task automatic chk(logic [7:0] got, int exp);
        n_checks++;
        if (got !== 8'(exp)) begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, got, 8'(exp));
        end
    endtask : chk
    task automatic reg_op(bit w, logic [3:0] a, logic [7:0] d);
        int e;
        reg_req <= '{a, d, w, !w};
        @(posedge clk_sys);
        reg_req <= '0;
        if (w && a == SRCR_ADDR_SLEEP_DEPTH_BIT_MODE) mode = d & 8'hC2;
        if (w && a == SRCR_ADDR_RAM_CTRL) ramen = d[4];
        e = a == 0 ? mode : a == 1 ? ramen * 16 : a == 2 ? sby : 0;
        #1;
        if (w) chk(trace_unit_rst_n_q, mode / 128);
        else chk(reg_rdata_q, e);
        @(posedge clk_sys);
    endtask : reg_op
    task automatic ram_op(bit w, logic [3:0] a, logic [7:0] d);
        ram_req <= '{a, d, w, !w};
        @(posedge clk_sys);
        ram_req <= '0;
        if (w && ramen) mem[a] = d;
        #1;
        if (!w) chk(ram_rdata_q, ramen ? mem[a] : SRCR_UNDEF_DATA);
        @(posedge clk_sys);
    endtask : ram_op
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1;
        @(posedge clk_sys);
        for (int i = 0; i < 3; i++) reg_op(0, i == 2 ? 4'hF : 4'(i), 0);
        for (int i = 0; i < 16; i++) ram_op(1, 4'(i), 8'($random(seed)));
        repeat (40) begin
            r = $random(seed);
            reg_op(r[8], {3'h0, r[9]}, r[23:16]);
            reg_op(0, SRCR_ADDR_RAM_CTRL, 0);
            ram_op(r[10], r[15:12], r[31:24]);
        end
        for (int i = 0; i < 4; i++) begin
            reg_op(1, 0, {1'b0, i[0], 4'h0, i != 2, 1'b0});
            pin_out <= 8'($random(seed));
            pin_oe <= 8'($random(seed));
            sleep_depth_bit <= i != 3;
            @(posedge clk_sys);
            sleep_exec <= 1;
            @(posedge clk_sys);
            sleep_exec <= 0;
            sby = sleep_depth_bit & mode[1];
            ho = pin_out;
            he = pin_oe;
            pin_out <= ~pin_out;
            pin_oe <= ~pin_oe;
            repeat (3) @(posedge clk_sys);
            #1;
            chk(standby_q, i < 2);
            chk(pad_out_q, i < 2 ? ho : ~ho);
            chk(pad_oe_q, i == 1 ? 0 : i < 2 ? he : ~he);
            @(posedge clk_sys);
            reg_op(0, SRCR_ADDR_STATUS, 0);
            standby_wake <= 1;
            @(posedge clk_sys);
            standby_wake <= 0;
            sby = 0;
            #1;
            chk(standby_q, 0);
            @(posedge clk_sys);
        end
        stop_test();
    end
endmodule : srcr_top_test
